// File: rtl/uci_top.sv
/*
 * per-channel interrupt priority and identification with a wishbone
 * register slave.
 * assumes status inputs come from same-clock uart logic, modem pins are
 * asynchronous, and bitTick comes from the baud divider.
 */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module uci_top
    import uci_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:2]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // channel status
    input  wire uci_evt_s    chanEvt,
    input  wire logic [7:0]  rxData,
    input  wire logic        bitTick,
    input  wire logic [3:0]  charBits,
    // modem pins: cts, dsr, ri, dcd
    input  wire logic [3:0]  modemPins,
    // outputs to the channel
    output logic             irqOut,
    output logic             rxReadStb,
    output logic             txWriteStb,
    output logic [7:0]       txData,
    output logic             fifoEnable
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       busReq;
    logic       busRd;
    logic       busWr;
    logic       rdIir;
    logic       rdLsr;
    logic       rdMsr;
    logic       rdRbr;
    logic       wrThr;
    logic       iirAccess;
    logic [7:0] ier_r;
    logic [1:0] flowCfg_r;
    logic [5:0] iirHeld_r;
    uci_src_e   srcNxt;
    logic [3:0] modemS;
    logic [3:0] modemPrev_r;
    logic [3:0] modemDelta_r;
    logic [3:0] lineErrPrev_r;
    logic       lineMuted_r;
    logic       txIntr_r;
    logic       thrPrev_r;
    logic       flowChar_r;
    logic       flowIsSpecial_r;
    logic       rtsPrev_r;
    logic       ctsIntr_r;
    logic       rtsIntr_r;
    logic       tmoExpired;

    assign busReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busRd     = busReq && !wb_we_i;
    assign busWr     = busReq && wb_we_i && wb_sel_i[0];
    assign rdIir     = busRd && (wb_adr_i == `UCI_IDX_IIR);
    assign rdLsr     = busRd && (wb_adr_i == `UCI_IDX_LSR);
    assign rdMsr     = busRd && (wb_adr_i == `UCI_IDX_MSR);
    assign rdRbr     = busRd && (wb_adr_i == `UCI_IDX_RXTX);
    assign wrThr     = busWr && (wb_adr_i == `UCI_IDX_RXTX);
    // freeze spans request and acknowledge cycles
    assign iirAccess = wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i == `UCI_IDX_IIR);

    // ------------------------------------------------------------------
    // pin synchroniser and timeout timer
    // ------------------------------------------------------------------
    uci_sync #(.W(4)) uModemSync (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pinLevel  (modemPins),
        .syncLevel (modemS)
    );

    // timeout timer four chars twelve bits
    uci_timeout uTimeout (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .bitTick  (bitTick),
        .charBits (charBits),
        .armed    (fifoEnable && (chanEvt.rxFill != 7'h00)),
        .restart  (rdRbr || chanEvt.rxCharSeen),
        .expired  (tmoExpired)
    );

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // writes at identification index reach fifo control
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ier_r      <= `UCI_IER_RST;
            flowCfg_r  <= 2'h0;
            fifoEnable <= 1'b0;
        end else if (busWr) begin
            if (wb_adr_i == `UCI_IDX_IER)
                ier_r <= wb_dat_i[7:0];
            if (wb_adr_i == `UCI_IDX_IIR)
                fifoEnable <= wb_dat_i[`UCI_FCR_FIFO_EN];
            if (wb_adr_i == `UCI_IDX_FLOWCFG)
                flowCfg_r <= wb_dat_i[1:0];
        end
    end

    // strobes and data toward the channel
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxReadStb  <= 1'b0;
            txWriteStb <= 1'b0;
            txData     <= 8'h00;
        end else begin
            rxReadStb  <= rdRbr;
            txWriteStb <= wrThr;
            if (wrThr)
                txData <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // source latches (set wins over clear throughout)
    // ------------------------------------------------------------------
    // line interrupt muted by status read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lineErrPrev_r <= 4'h0;
            lineMuted_r   <= 1'b0;
        end else begin
            lineErrPrev_r <= chanEvt.lineErr;
            if ((chanEvt.lineErr & ~lineErrPrev_r) != 4'h0)
                lineMuted_r <= 1'b0;
            else if (rdLsr)
                lineMuted_r <= 1'b1;
            else if (chanEvt.lineErr == 4'h0)
                lineMuted_r <= 1'b0;
        end
    end

    // tx empty set on empty, cleared by read or write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            thrPrev_r <= 1'b0;
            txIntr_r  <= 1'b0;
        end else begin
            thrPrev_r <= chanEvt.thrEmpty;
            if (chanEvt.thrEmpty && !thrPrev_r)
                txIntr_r <= 1'b1;
            else if (wrThr || (rdIir && iirHeld_r == `UCI_IIR_THR))
                txIntr_r <= 1'b0;
        end
    end

    // modem change sticky until status read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            modemPrev_r  <= 4'h0;
            modemDelta_r <= 4'h0;
        end else begin
            modemPrev_r  <= modemS;
            modemDelta_r <= (modemS ^ modemPrev_r) | (rdMsr ? 4'h0 : modemDelta_r);
        end
    end

    // flow character latch and its clears
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flowChar_r      <= 1'b0;
            flowIsSpecial_r <= 1'b0;
        end else if (chanEvt.xoffSeen || chanEvt.specialSeen) begin
            flowChar_r      <= 1'b1;
            flowIsSpecial_r <= chanEvt.specialSeen && !chanEvt.xoffSeen;
        end else if ((rdIir && iirHeld_r == `UCI_IIR_XOFF)
                     || (!flowIsSpecial_r && chanEvt.xonSeen)
                     || (flowIsSpecial_r && chanEvt.rxCharSeen)) begin
            flowChar_r <= 1'b0;
        end
    end

    // rising edges under auto flow control
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rtsPrev_r <= 1'b0;
            ctsIntr_r <= 1'b0;
            rtsIntr_r <= 1'b0;
        end else begin
            rtsPrev_r <= chanEvt.rtsLevel;
            if (flowCfg_r[`UCI_CFG_AUTOCTS] && modemS[0] && !modemPrev_r[0])
                ctsIntr_r <= 1'b1;
            else if (rdIir || rdMsr)
                ctsIntr_r <= 1'b0;
            if (flowCfg_r[`UCI_CFG_AUTORTS] && chanEvt.rtsLevel && !rtsPrev_r)
                rtsIntr_r <= 1'b1;
            else if (rdIir || rdMsr)
                rtsIntr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // priority selection
    // ------------------------------------------------------------------
    // masked ranking of seven levels
    always_comb begin
        srcNxt = SRC_NONE;
        if (ier_r[`UCI_IER_LINE] && chanEvt.lineErr != 4'h0 && !lineMuted_r)
            srcNxt = SRC_LINE;
        else if (ier_r[`UCI_IER_RXD] && tmoExpired)
            srcNxt = SRC_TMO;
        else if (ier_r[`UCI_IER_RXD] && chanEvt.rxFill != 7'h00
                 && chanEvt.rxFill >= chanEvt.rxTrig)
            srcNxt = SRC_RXD;
        else if (ier_r[`UCI_IER_THR] && txIntr_r)
            srcNxt = SRC_THR;
        else if (ier_r[`UCI_IER_MDM] && modemDelta_r != 4'h0)
            srcNxt = SRC_MDM;
        else if (ier_r[`UCI_IER_XOFF] && flowChar_r)
            srcNxt = SRC_XOFF;
        else if ((ier_r[`UCI_IER_CTS] && ctsIntr_r) || (ier_r[`UCI_IER_RTS] && rtsIntr_r))
            srcNxt = SRC_FLOW;
    end

    // held indication frozen while the host reads it
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            iirHeld_r <= `UCI_IIR_NONE;
        else if (!iirAccess)
            iirHeld_r <= uci_code(srcNxt);
    end

    // interrupt output from the live masked sources
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            irqOut <= 1'b0;
        else
            irqOut <= (srcNxt != SRC_NONE);
    end

    // ------------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            if (busRd) begin
                unique case (wb_adr_i)
                    `UCI_IDX_RXTX:    wb_dat_o <= {24'h00_0000, rxData};
                    `UCI_IDX_IER:     wb_dat_o <= {24'h00_0000, ier_r};
                    `UCI_IDX_IIR:     wb_dat_o <= {24'h00_0000,
                                          fifoEnable ? `UCI_IIR_FIFO_ON : `UCI_IIR_FIFO_OFF,
                                          iirHeld_r};
                    `UCI_IDX_LSR:     wb_dat_o <= {24'h00_0000, 3'h0,
                                          chanEvt.lineErr, chanEvt.rxFill != 7'h00};
                    `UCI_IDX_MSR:     wb_dat_o <= {24'h00_0000, modemS, modemDelta_r};
                    `UCI_IDX_FLOWCFG: wb_dat_o <= {30'h0000_0000, flowCfg_r};
                    default:          wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_freeze_hold: assert property (iirAccess && $past(iirAccess) |-> $stable(iirHeld_r))
        else $error("identification changed during read");
    chk_fifo_bits: assert property (wb_ack_o && $past(rdIir) |->
        wb_dat_o[7:6] == {2{$past(fifoEnable)}})
        else $error("fifo status bits wrong");
    chk_none_code: assert property (!iirAccess && srcNxt == SRC_NONE |=> iirHeld_r == 6'h01)
        else $error("idle code wrong");
    chk_line_top: assert property (!iirAccess && srcNxt == SRC_LINE |=> iirHeld_r == 6'h06)
        else $error("line code wrong");
    chk_xoff_code: assert property (!iirAccess && srcNxt == SRC_XOFF |=> iirHeld_r == 6'h10)
        else $error("flow character code wrong");
    chk_flow_code: assert property (!iirAccess && srcNxt == SRC_FLOW |=> iirHeld_r == 6'h20)
        else $error("rts cts code wrong");
    chk_mask_irq: assert property (ier_r == 8'h00 |=> !irqOut)
        else $error("masked source raised interrupt");
    chk_thr_clear: assert property (wrThr && !(chanEvt.thrEmpty && !thrPrev_r) |=> !txIntr_r)
        else $error("tx interrupt not cleared");
    chk_msr_clear: assert property (rdMsr && modemS == modemPrev_r |=>
        modemDelta_r == 4'h0 && !ctsIntr_r)
        else $error("modem read did not clear");
    chk_ack_one: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not one cycle");

    cov_line_read: cover property (srcNxt == SRC_LINE ##1 rdLsr ##2 srcNxt != SRC_LINE);
    cov_iir_freeze: cover property (iirAccess && srcNxt != SRC_NONE ##1 iirAccess);
    cov_timeout: cover property (tmoExpired ##[1:20] rdRbr);
    cov_flow_irq: cover property (srcNxt == SRC_FLOW ##1 irqOut);

endmodule : uci_top

`default_nettype wire

// File: rtl/uci_params.svh
/*
 * constants for the per-channel interrupt priority block: register
 * indices, field positions, reset values and timeout figures.
 * assumes inclusion by its bare name from the package, the one file that includes it.
 */
`ifndef UCI_PARAMS_SVH
`define UCI_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define UCI_IDX_RXTX     4'h0
`define UCI_IDX_IER      4'h1
`define UCI_IDX_IIR      4'h2
`define UCI_IDX_LSR      4'h5
`define UCI_IDX_MSR      4'h6
`define UCI_IDX_FLOWCFG  4'h8

// ----------------------------------------------------------------------
// enable register fields
// ----------------------------------------------------------------------
`define UCI_IER_RXD      0
`define UCI_IER_THR      1
`define UCI_IER_LINE     2
`define UCI_IER_MDM      3
`define UCI_IER_XOFF     5
`define UCI_IER_RTS      6
`define UCI_IER_CTS      7
`define UCI_IER_RST      8'h00

// ----------------------------------------------------------------------
// identification codes, bits 5:0
// ----------------------------------------------------------------------
`define UCI_IIR_NONE     6'h01
`define UCI_IIR_LINE     6'h06
`define UCI_IIR_TMO      6'h0c
`define UCI_IIR_RXD      6'h04
`define UCI_IIR_THR      6'h02
`define UCI_IIR_MDM      6'h00
`define UCI_IIR_XOFF     6'h10
`define UCI_IIR_FLOW     6'h20
`define UCI_IIR_FIFO_ON  2'h3
`define UCI_IIR_FIFO_OFF 2'h0

// ----------------------------------------------------------------------
// fifo control and flow configuration fields
// ----------------------------------------------------------------------
`define UCI_FCR_FIFO_EN  0
`define UCI_CFG_AUTOCTS  0
`define UCI_CFG_AUTORTS  1

// ----------------------------------------------------------------------
// receive timeout: four characters plus twelve bits
// ----------------------------------------------------------------------
`define UCI_TMO_CHARS    7'h04
`define UCI_TMO_BITS     7'h0c

`endif

// File: rtl/uci_pkg.sv
/*
 * types shared by the interrupt priority block.
 * assumes uci_params.svh is on the include path.
 */
`include "uci_params.svh"

package uci_pkg;

    // ------------------------------------------------------------------
    // no-source value, then pending sources, highest priority first
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_NONE, SRC_LINE, SRC_TMO, SRC_RXD, SRC_THR, SRC_MDM, SRC_XOFF, SRC_FLOW
    } uci_src_e;

    // status from the rest of the channel, same clock
    typedef struct packed {
        logic [3:0] lineErr;     // break, framing, parity, overrun
        logic [6:0] rxFill;
        logic [6:0] rxTrig;
        logic       thrEmpty;
        logic       xoffSeen;    // pulse
        logic       specialSeen; // pulse
        logic       xonSeen;     // pulse
        logic       rxCharSeen;  // pulse
        logic       rtsLevel;
    } uci_evt_s;

    // identification code for a source
    function automatic logic [5:0] uci_code(input uci_src_e src);
        unique case (src)
            SRC_NONE: uci_code = `UCI_IIR_NONE;
            SRC_LINE: uci_code = `UCI_IIR_LINE;
            SRC_TMO:  uci_code = `UCI_IIR_TMO;
            SRC_RXD:  uci_code = `UCI_IIR_RXD;
            SRC_THR:  uci_code = `UCI_IIR_THR;
            SRC_MDM:  uci_code = `UCI_IIR_MDM;
            SRC_XOFF: uci_code = `UCI_IIR_XOFF;
            SRC_FLOW: uci_code = `UCI_IIR_FLOW;
        endcase
    endfunction : uci_code

endpackage : uci_pkg

// File: rtl/uci_sync.sv
/*
 * two flip-flop synchroniser for pin levels.
 * assumes pins change asynchronously to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module uci_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // levels
    input  wire logic [W-1:0] pinLevel,
    output logic      [W-1:0] syncLevel
);

    logic [W-1:0] stage1_r;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage1_r  <= '0;
            syncLevel <= '0;
        end else begin
            stage1_r  <= pinLevel;
            syncLevel <= stage1_r;
        end
    end

endmodule : uci_sync

`default_nettype wire

// File: rtl/uci_timeout.sv
/*
 * receive timeout timer counted in bit-time enable pulses.
 * assumes bitTick is a one-cycle pulse from the baud divider.
 */
`timescale 1ns/1ps
`default_nettype none

module uci_timeout
    import uci_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // timing
    input  wire logic       bitTick,
    input  wire logic [3:0] charBits,
    // activity
    input  wire logic       armed,
    input  wire logic       restart,
    output logic            expired
);

    logic [6:0] count_r;
    logic [6:0] limit;

    assign limit = 7'(`UCI_TMO_CHARS * {3'h0, charBits}) + `UCI_TMO_BITS;

    // count idle bit times while data waits; restart on any activity
    always_ff @(posedge core_clk) begin
        if (sys_rst || restart || !armed) begin
            count_r <= 7'h00;
            expired <= 1'b0;
        end else if (bitTick && !expired) begin
            count_r <= count_r + 7'h01;
            expired <= (count_r + 7'h01) >= limit;
        end
    end

endmodule : uci_timeout

`default_nettype wire

// File: testbench/uci_host_model.sv
/*
 * host master model: classic wishbone single cycles.
 * assumes one ack per request on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module uci_host_model (
    // clock and answer
    input  wire logic        core_clk,
    input  wire logic        wb_ack_o,
    // request
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic [5:2]       wb_adr_i,
    output logic [3:0]       wb_sel_i,
    output logic [31:0]      wb_dat_i
);
    // idle bus at time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end

    // one request, held until ack is sampled high
    task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer
endmodule : uci_host_model
`default_nettype wire

// File: testbench/uci_top_tb.sv
/*
 * self-checking bench for uci_top: register traffic and channel events.
 * assumes uci_host_model is the bus master.
 */
`timescale 1ns/1ps
`default_nettype none

module uci_top_tb import uci_pkg::*;;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:2]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [3:0]  modemPins = 4'h0;
    logic [3:0]  charBits  = 4'h8;
    logic [31:0] wb_dat_i, wb_dat_o;
    uci_evt_s    evt = '0;
    logic [7:0]  rxData = 8'h00;
    logic [7:0]  txData, r;
    logic        bitTick = 1'b0;
    logic        irqOut, rxReadStb, txWriteStb, fifoEnable;
    int          errors = 0;
    int          total_checks = 0;
    logic [31:0] expQ[$];

    uci_host_model host_i (.core_clk(core_clk), .wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i));
    uci_top uci_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chanEvt(evt),
        .rxData(rxData), .bitTick(bitTick), .charBits(charBits), .modemPins(modemPins),
        .irqOut(irqOut), .rxReadStb(rxReadStb), .txWriteStb(txWriteStb), .txData(txData),
        .fifoEnable(fifoEnable));

    // clock
    always #4 core_clk = ~core_clk;

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // read notes the expected byte for the monitor
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back({24'h0, e});
        host_i.xfer(a, 1'b0, 8'h00);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // one-cycle pulse on an event field selected by index
    task automatic pulse(input int f);
        case (f)
            0: evt.xoffSeen <= 1'b1;
            1: evt.xonSeen <= 1'b1;
            2: evt.specialSeen <= 1'b1;
            default: evt.rxCharSeen <= 1'b1;
        endcase
        tick(1);
        {evt.xoffSeen, evt.xonSeen, evt.specialSeen, evt.rxCharSeen} <= 4'h0;
        tick(2);
    endtask : pulse

    // monitor: oldest note against each read answer
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("rdata", wb_dat_o, expQ.pop_front());
    end

    // watchdog
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end

    // main sequence
    initial begin
        void'($urandom(32'h6f37));
        rxData <= 8'($urandom);
        tick(8);
        sys_rst <= 1'b0;
        rd(4'h2, 8'h01);
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        check("irq", irqOut, 32'h0);
        r = 8'($urandom);
        host_i.xfer(4'h1, 1'b1, r);
        rd(4'h1, r);
        host_i.xfer(4'h2, 1'b1, 8'h01);
        check("fifo", fifoEnable, 32'h1);
        rd(4'h2, 8'hc1);
        host_i.xfer(4'h8, 1'b1, 8'h02);
        host_i.xfer(4'h1, 1'b1, 8'hef);
        $display("test setup done");
        evt.lineErr <= 4'h1;
        evt.rxFill <= 7'h08;
        evt.rxTrig <= 7'h04;
        evt.thrEmpty <= 1'b1;
        modemPins <= 4'h2;
        pulse(0);
        tick(3);
        check("irq", irqOut, 32'h1);
        rd(4'h2, 8'hc6);
        rd(4'h5, 8'h03);
        rd(4'h2, 8'hc4);
        evt.rxFill <= 7'h02;
        tick(2);
        rd(4'h2, 8'hc2);
        rd(4'h2, 8'hc0);
        rd(4'h6, 8'h22);
        rd(4'h2, 8'hd0);
        rd(4'h2, 8'hc1);
        evt.rtsLevel <= 1'b1;
        tick(3);
        rd(4'h2, 8'he0);
        rd(4'h2, 8'hc1);
        // cts rise under auto cts, modem change masked so level seven shows
        host_i.xfer(4'h8, 1'b1, 8'h03);
        host_i.xfer(4'h1, 1'b1, 8'he7);
        modemPins <= 4'h3;
        tick(4);
        rd(4'h2, 8'he0);
        rd(4'h6, 8'h31);
        rd(4'h2, 8'hc1);
        host_i.xfer(4'h1, 1'b1, 8'hef);
        $display("test priority done");
        pulse(0);
        pulse(1);
        rd(4'h2, 8'hc1);
        pulse(2);
        rd(4'h2, 8'hd0);
        pulse(2);
        pulse(3);
        rd(4'h2, 8'hc1);
        evt.thrEmpty <= 1'b0;
        tick(2);
        evt.thrEmpty <= 1'b1;
        tick(3);
        r = 8'($urandom);
        host_i.xfer(4'h0, 1'b1, r);
        check("txstb", txWriteStb, 32'h1);
        check("txd", txData, {24'h0, r});
        rd(4'h2, 8'hc1);
        $display("test flow done");
        repeat (50) begin
            bitTick <= 1'b1;
            tick(1);
            bitTick <= 1'b0;
            tick(1);
        end
        rd(4'h2, 8'hcc);
        rd(4'h0, rxData);
        rd(4'h2, 8'hc1);
        host_i.xfer(4'h1, 1'b1, 8'h00);
        pulse(0);
        check("irq", irqOut, 32'h0);
        rd(4'h2, 8'hc1);
        $display("test timeout and mask done");
        report_and_stop();
    end
endmodule : uci_top_tb
`default_nettype wire
